/* File: iod_space_decode.sv */
// decoder and register bank for the low i/o register space
// the core drives one request per cycle and waits for ack
// peripherals drive status and flag-set bytes per i/o address
`include "iod_params.svh"
`timescale 1ns/10ps
`default_nettype none

module iod_space_decode
    import iod_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire iod_req_t req_in,
    input wire logic [7:0] hw_status_in [`IOD_IO_SPAN],
    input wire logic [7:0] hw_flag_set_in [`IOD_IO_SPAN],
    input wire logic [7:0] ext_rdata_in,
    output var iod_rsp_t rsp_out,
    output var iod_ext_t ext_out,
    output var logic [7:0] io_reg_out [`IOD_IO_SPAN]
);

    // ==========================================
    // bit classification per i/o address

    // bits that exist at all; the rest read zero
    function automatic logic [7:0] impl_mask(input logic [5:0] a);
        logic [7:0] m;
        m = `IOD_NO_MASK;
        if (a <= `IOD_PORT_LAST) begin
            m = `IOD_FULL_MASK;
            if (a == `IOD_PORT_G_PIN) begin
                m = `IOD_PORT_G_PIN_MASK;
            end else if (a == `IOD_PORT_G_DIR || a == `IOD_PORT_G_OUT) begin
                m = `IOD_PORT_G_MASK;
            end
        end else begin
            unique case (a)
                `IOD_TMR0_FLAGS: m = `IOD_TMR0_FLAG_MASK;
                `IOD_TMR1_FLAGS: m = `IOD_TMR1_FLAG_MASK;
                `IOD_TMR2_FLAGS: m = `IOD_TMR2_FLAG_MASK;
                `IOD_EXT_IRQ_FLAGS: m = `IOD_EXT_IRQ_BITS;
                `IOD_EXT_IRQ_MASK: m = `IOD_EXT_IRQ_BITS;
                `IOD_NV_CTRL: m = `IOD_NV_CTRL_MASK;
                `IOD_NV_ADDR_HI: m = `IOD_NV_ADDR_HI_MASK;
                `IOD_PRESCALE_CTRL: m = `IOD_PRESCALE_MASK;
                `IOD_SER_STAT: m = `IOD_SER_STAT_MASK;
                `IOD_SLEEP_CTRL: m = `IOD_SLEEP_MASK;
                `IOD_RESET_CAUSE: m = `IOD_RESET_CAUSE_MASK;
                `IOD_CORE_CTRL: m = `IOD_CORE_CTRL_MASK;
                `IOD_SELF_PROG: m = `IOD_SELF_PROG_MASK;
                `IOD_SCRATCH0,
                `IOD_NV_DATA,
                `IOD_NV_ADDR_LO,
                `IOD_TMR0_CTRL,
                `IOD_TMR0_COUNT,
                `IOD_TMR0_CMP,
                `IOD_SCRATCH1,
                `IOD_SCRATCH2,
                `IOD_SER_CTRL,
                `IOD_SER_DATA,
                `IOD_CMP_CTRL,
                `IOD_DEBUG_DATA: m = `IOD_FULL_MASK;
                default: m = `IOD_NO_MASK;
            endcase
        end
        return m;
    endfunction

    // bits whose value comes from the peripheral, never stored
    function automatic logic [7:0] ro_mask(input logic [5:0] a);
        logic [7:0] m;
        m = `IOD_NO_MASK;
        if (a <= `IOD_PORT_LAST) begin
            if ((a % `IOD_PORT_STRIDE) == 6'h00) begin
                m = impl_mask(a);
            end
        end else begin
            unique case (a)
                `IOD_SER_STAT: m = `IOD_SER_STAT_RO;
                `IOD_CMP_CTRL: m = `IOD_CMP_RO;
                `IOD_SELF_PROG: m = `IOD_SELF_PROG_RO;
                default: m = `IOD_NO_MASK;
            endcase
        end
        return m;
    endfunction

    // flags set by hardware and cleared by writing one
    function automatic logic [7:0] w1c_mask(input logic [5:0] a);
        logic [7:0] m;
        m = `IOD_NO_MASK;
        unique case (a)
            `IOD_TMR0_FLAGS,
            `IOD_TMR1_FLAGS,
            `IOD_TMR2_FLAGS,
            `IOD_EXT_IRQ_FLAGS: m = impl_mask(a);
            `IOD_CMP_CTRL: m = `IOD_CMP_W1C;
            default: m = `IOD_NO_MASK;
        endcase
        return m;
    endfunction

    // ==========================================
    // address reach of each instruction class

    // single-bit set, clear and skip tests
    function automatic logic bit_reach(input logic [7:0] a);
        return a <= `IOD_BIT_LAST;
    endfunction

    // port-style in and out; nothing above 64 locations
    function automatic logic port_reach(input logic [7:0] a);
        return a <= `IOD_IO_LAST;
    endfunction

    // data addresses that alias the i/o window
    function automatic logic data_io_reach(input logic [7:0] a);
        return (a >= `IOD_DATA_IO_BASE) && (a < `IOD_EXT_BASE);
    endfunction

    // store variants of load/store carry an odd code
    function automatic logic is_store(input iod_op_t op);
        return op[0];
    endfunction

    // ==========================================
    // request decode

    iod_state_t state_q;
    iod_state_t state_d;
    logic io_rd;
    logic io_wr;
    logic bit_test;
    logic ext_hit;
    logic bad_acc;
    logic [5:0] io_addr;
    logic [7:0] wr_mask;
    logic [7:0] wr_data;
    logic [7:0] data_off;

    // data address minus the i/o window base
    assign data_off = req_in.addr - `IOD_DATA_IO_BASE;

    always_comb begin
        io_rd = 1'b0;
        io_wr = 1'b0;
        bit_test = 1'b0;
        ext_hit = 1'b0;
        bad_acc = 1'b0;
        io_addr = req_in.addr[5:0];
        wr_mask = `IOD_NO_MASK;
        wr_data = req_in.wdata;
        if (req_in.valid && state_q == IOD_IDLE) begin
            unique case (req_in.op)
                port_in_op,
                port_out_op: begin
                    // only 64 locations; anything above is refused
                    if (port_reach(req_in.addr)) begin
                        io_rd = (req_in.op == port_in_op);
                        io_wr = (req_in.op == port_out_op);
                        wr_mask = `IOD_FULL_MASK;
                    end else begin
                        bad_acc = 1'b1;
                    end
                end
                set_single_bit_op,
                clear_single_bit_op: begin
                    if (bit_reach(req_in.addr)) begin
                        io_wr = 1'b1;
                        // one-hot mask keeps neighbouring flags intact
                        wr_mask = `IOD_BIT_ONE << req_in.bit_sel;
                        if (req_in.op == set_single_bit_op) begin
                            wr_data = `IOD_FULL_MASK;
                        end else begin
                            wr_data = `IOD_NO_MASK;
                        end
                    end else begin
                        bad_acc = 1'b1;
                    end
                end
                skip_if_bit_set_op,
                skip_if_bit_clear_op: begin
                    if (bit_reach(req_in.addr)) begin
                        io_rd = 1'b1;
                        bit_test = 1'b1;
                    end else begin
                        bad_acc = 1'b1;
                    end
                end
                load_indirect_op,
                load_direct_op,
                load_displaced_op,
                store_indirect_op,
                store_direct_op,
                store_displaced_op: begin
                    // below the window is the core's own register file
                    if (req_in.addr < `IOD_DATA_IO_BASE) begin
                        bad_acc = 1'b1;
                    end else if (data_io_reach(req_in.addr)) begin
                        io_addr = data_off[5:0];
                        io_rd = !is_store(req_in.op);
                        io_wr = is_store(req_in.op);
                        wr_mask = `IOD_FULL_MASK;
                    end else begin
                        ext_hit = 1'b1;
                    end
                end
                default: bad_acc = 1'b1;
            endcase
        end
    end

    // ==========================================
    // register bank, one byte per i/o address

    logic [7:0] io_q [`IOD_IO_SPAN];
    logic [7:0] rd_val [`IOD_IO_SPAN];

    genvar gi;
    generate
        for (gi = 0; gi < `IOD_IO_SPAN; gi++) begin : g_byte
            localparam logic [5:0] ADDR = 6'(gi);
            localparam logic [7:0] IMPL = impl_mask(ADDR);
            localparam logic [7:0] RO = ro_mask(ADDR);
            localparam logic [7:0] W1C = w1c_mask(ADDR);
            localparam logic [7:0] RW = IMPL & ~RO & ~W1C;

            logic hit;
            logic [7:0] wm;
            logic [7:0] clr;
            logic [7:0] io_d;

            assign hit = io_wr && (io_addr == ADDR);
            // reserved bits and addresses never take a write
            assign wm = hit ? wr_mask : `IOD_NO_MASK;
            assign clr = wr_data & wm & W1C;

            always_comb begin
                io_d = (io_q[gi] & ~(wm & RW)) | (wr_data & wm & RW);
                // a flag raised in the clearing cycle survives
                io_d = (io_d & ~clr) | (hw_flag_set_in[gi] & W1C);
                io_d = io_d & (RW | W1C);
            end

            always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    io_q[gi] <= `IOD_RESET_VAL;
                end else begin
                    io_q[gi] <= io_d;
                end
            end

            // live status bits merge with stored ones on read
            assign rd_val[gi] = (io_q[gi] & (RW | W1C)) | (hw_status_in[gi] & RO);
            assign io_reg_out[gi] = io_q[gi];
        end
    endgenerate

    // ==========================================
    // read path

    logic [7:0] rd_byte;
    logic rd_bit;

    always_comb begin
        rd_byte = rd_val[io_addr];
        rd_bit = rd_byte[req_in.bit_sel];
    end

    // ==========================================
    // extended space handshake

    // extended peripherals answer in the same cycle as the strobe
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            IOD_IDLE: begin
                if (ext_hit) begin
                    state_d = IOD_EXT_WAIT;
                end
            end
            IOD_EXT_WAIT: begin
                state_d = IOD_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= IOD_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_out <= '0;
        end else begin
            ext_out.valid <= ext_hit;
            ext_out.write <= ext_hit && is_store(req_in.op);
            if (ext_hit) begin
                ext_out.addr <= req_in.addr;
                ext_out.wdata <= req_in.wdata;
            end
        end
    end

    // ==========================================
    // response to the core

    logic ack_q;
    logic err_q;
    logic [7:0] rdata_q;
    logic bit_val_q;
    logic skip_q;

    // i/o and refused answers come next cycle, extended ones a cycle later
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ack_q <= io_rd || io_wr || bad_acc || (state_q == IOD_EXT_WAIT);
            err_q <= bad_acc;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= `IOD_RESET_VAL;
        end else if (state_q == IOD_EXT_WAIT) begin
            // write answers carry no data
            rdata_q <= ext_out.write ? `IOD_NO_MASK : ext_rdata_in;
        end else if (io_rd) begin
            rdata_q <= rd_byte;
        end else begin
            rdata_q <= `IOD_NO_MASK;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_val_q <= 1'b0;
            skip_q <= 1'b0;
        end else begin
            bit_val_q <= bit_test && rd_bit;
            if (!bit_test) begin
                skip_q <= 1'b0;
            end else if (req_in.op == skip_if_bit_set_op) begin
                skip_q <= rd_bit;
            end else begin
                skip_q <= !rd_bit;
            end
        end
    end

    assign rsp_out = '{ack: ack_q, err: err_q, rdata: rdata_q, bit_val: bit_val_q, skip: skip_q};

endmodule

`default_nettype wire

/* File: iod_params.svh */
// constants for the low i/o register space decoder
// included by iod_space_decode.sv, the checker and the bench, not by iod_pkg.sv
`ifndef IOD_PARAMS_SVH
`define IOD_PARAMS_SVH

// ==========================================
// space layout
`define IOD_IO_SPAN 64
`define IOD_IO_LAST 8'h3F
`define IOD_BIT_LAST 8'h1F
`define IOD_DATA_IO_BASE 8'h20
`define IOD_EXT_BASE 8'h60
`define IOD_RESET_VAL 8'h00
`define IOD_FULL_MASK 8'hFF
`define IOD_NO_MASK 8'h00
`define IOD_BIT_ONE 8'h01

// ==========================================
// port blocks: pin input, direction, output
`define IOD_PORT_STRIDE 3
`define IOD_PORT_LAST 6'h14
`define IOD_PORT_G_PIN 6'h12
`define IOD_PORT_G_DIR 6'h13
`define IOD_PORT_G_OUT 6'h14

// ==========================================
// other register offsets
`define IOD_TMR0_FLAGS 6'h15
`define IOD_TMR1_FLAGS 6'h16
`define IOD_TMR2_FLAGS 6'h17
`define IOD_EXT_IRQ_FLAGS 6'h1C
`define IOD_EXT_IRQ_MASK 6'h1D
`define IOD_SCRATCH0 6'h1E
`define IOD_NV_CTRL 6'h1F
`define IOD_NV_DATA 6'h20
`define IOD_NV_ADDR_LO 6'h21
`define IOD_NV_ADDR_HI 6'h22
`define IOD_PRESCALE_CTRL 6'h23
`define IOD_TMR0_CTRL 6'h24
`define IOD_TMR0_COUNT 6'h26
`define IOD_TMR0_CMP 6'h27
`define IOD_SCRATCH1 6'h2A
`define IOD_SCRATCH2 6'h2B
`define IOD_SER_CTRL 6'h2C
`define IOD_SER_STAT 6'h2D
`define IOD_SER_DATA 6'h2E
`define IOD_CMP_CTRL 6'h31
`define IOD_DEBUG_DATA 6'h32
`define IOD_SLEEP_CTRL 6'h33
`define IOD_RESET_CAUSE 6'h34
`define IOD_CORE_CTRL 6'h35
`define IOD_SELF_PROG 6'h37

// ==========================================
// implemented, read-only and write-one-to-clear bits
`define IOD_PORT_G_MASK 8'h1F
`define IOD_PORT_G_PIN_MASK 8'h3F
`define IOD_TMR0_FLAG_MASK 8'h03
`define IOD_TMR1_FLAG_MASK 8'h27
`define IOD_TMR2_FLAG_MASK 8'h03
`define IOD_EXT_IRQ_BITS 8'hF1
`define IOD_NV_CTRL_MASK 8'h0F
`define IOD_NV_ADDR_HI_MASK 8'h07
`define IOD_PRESCALE_MASK 8'h83
`define IOD_SER_STAT_MASK 8'hC1
`define IOD_SER_STAT_RO 8'hC0
`define IOD_CMP_RO 8'h20
`define IOD_CMP_W1C 8'h10
`define IOD_SLEEP_MASK 8'h0F
`define IOD_RESET_CAUSE_MASK 8'h1F
`define IOD_CORE_CTRL_MASK 8'h93
`define IOD_SELF_PROG_MASK 8'hDF
`define IOD_SELF_PROG_RO 8'h40

`endif

/* File: iod_pkg.sv */
// types shared by the i/o register space decoder
// needs nothing from iod_params.svh and includes no file
`default_nettype none

package iod_pkg;

    // ==========================================
    // access kinds issued by the core
    typedef enum logic [3:0] {
        port_in_op = 4'h0,
        port_out_op = 4'h1,
        set_single_bit_op = 4'h2,
        clear_single_bit_op = 4'h3,
        skip_if_bit_set_op = 4'h4,
        skip_if_bit_clear_op = 4'h5,
        load_indirect_op = 4'h6,
        store_indirect_op = 4'h7,
        load_direct_op = 4'h8,
        store_direct_op = 4'h9,
        load_displaced_op = 4'hA,
        store_displaced_op = 4'hB
    } iod_op_t;

    typedef enum logic [0:0] {
        IOD_IDLE = 1'b0,
        IOD_EXT_WAIT = 1'b1
    } iod_state_t;

    typedef struct packed {
        logic valid;
        iod_op_t op;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } iod_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [7:0] rdata;
        logic bit_val;
        logic skip;
    } iod_rsp_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } iod_ext_t;

endpackage

`default_nettype wire

/* File: iod_ext_model.sv */
// far-side model of the extended register space behind the decoder
// assumes iod_pkg is compiled first and one clock domain
`timescale 1ns/10ps
`default_nettype none

module iod_ext_model
    import iod_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire iod_ext_t ext_in,
    output wire logic [7:0] rdata_out
);
    logic [7:0] mem_q [256];
    logic [7:0] junk_q;

    // ====================
    // storage, reached only by load and store
    always @(posedge ref_clk_in) begin
        if (ext_in.valid && ext_in.write) begin
            mem_q[ext_in.addr] <= ext_in.wdata;
        end
    end

    // read data only while selected; otherwise a pattern that moves every cycle
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            junk_q <= 8'hA5;
        end else begin
            junk_q <= {junk_q[6:0], ~junk_q[7]};
        end
    end
    assign rdata_out = (ext_in.valid && !ext_in.write) ? mem_q[ext_in.addr] : junk_q;
endmodule

`default_nettype wire

/* File: iod_space_decode_assertions.sv */
// concurrent checks on the ports of the i/o register space decoder
// assumes iod_pkg and iod_space_decode are compiled first
`include "iod_params.svh"
`timescale 1ns/10ps
`default_nettype none

module iod_chk
    import iod_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire iod_req_t req_in,
    input wire logic [7:0] hw_status_in [`IOD_IO_SPAN],
    input wire logic [7:0] hw_flag_set_in [`IOD_IO_SPAN],
    input wire iod_rsp_t rsp_out,
    input wire iod_ext_t ext_out,
    input wire logic [7:0] io_reg_out [`IOD_IO_SPAN]
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    // ====================
    // request classes; a request in the extended wait cycle is not taken
    wire logic go = req_in.valid && !ext_out.valid;
    wire logic io_op = req_in.op == port_in_op || req_in.op == port_out_op;
    wire logic bit_op = req_in.op inside {[set_single_bit_op:skip_if_bit_clear_op]};
    wire logic ls_op = req_in.op >= load_indirect_op;
    wire logic ext_go = go && ls_op && req_in.addr >= `IOD_EXT_BASE;
    wire logic [5:0] ia = req_in.addr[5:0];

    // ====================
    // properties
    property p_io_range;
        go && io_op && req_in.addr > `IOD_IO_LAST |=> rsp_out.ack && rsp_out.err;
    endproperty
    a_io_range: assert property (p_io_range) else $error("in/out beyond range accepted");

    property p_io_ok;
        go && io_op && req_in.addr <= `IOD_IO_LAST |=> rsp_out.ack && !rsp_out.err;
    endproperty
    a_io_ok: assert property (p_io_ok) else $error("in/out in range refused");

    property p_bit_range;
        go && bit_op && req_in.addr > `IOD_BIT_LAST |=> rsp_out.ack && rsp_out.err;
    endproperty
    a_bit_range: assert property (p_bit_range) else $error("bit op beyond range accepted");

    property p_ls_low;
        go && ls_op && req_in.addr < `IOD_DATA_IO_BASE |=> rsp_out.ack && rsp_out.err;
    endproperty
    a_ls_low: assert property (p_ls_low) else $error("load/store below base accepted");

    property p_ext;
        ext_go |=> ext_out.valid && ext_out.addr == $past(req_in.addr) && ext_out.write == $past(req_in.op[0])
            ##1 rsp_out.ack && !rsp_out.err;
    endproperty
    a_ext: assert property (p_ext) else $error("extended access wrong");

    property p_ext_src;
        ext_out.valid |-> $past(ext_go);
    endproperty
    a_ext_src: assert property (p_ext_src) else $error("extended strobe without load/store");

    property p_map;
        go && req_in.op[0] && ls_op && req_in.addr == `IOD_DATA_IO_BASE + `IOD_SCRATCH0
        |=> io_reg_out[`IOD_SCRATCH0] == $past(req_in.wdata);
    endproperty
    a_map: assert property (p_map) else $error("store not mapped with offset");

    property p_skip;
        go && req_in.op == skip_if_bit_set_op && req_in.addr == 8'h00
        |=> rsp_out.ack && rsp_out.skip == rsp_out.bit_val && rsp_out.bit_val == $past(hw_status_in[0][req_in.bit_sel]);
    endproperty
    a_skip: assert property (p_skip) else $error("skip test bit wrong");

    property p_only_bit;
        go && req_in.op inside {set_single_bit_op, clear_single_bit_op} && req_in.addr <= `IOD_BIT_LAST
            && hw_flag_set_in[ia] == `IOD_NO_MASK
        |=> ((io_reg_out[$past(ia)] ^ $past(io_reg_out[ia])) & ~(`IOD_BIT_ONE << $past(req_in.bit_sel))) == 8'h00;
    endproperty
    a_only_bit: assert property (p_only_bit) else $error("bit op touched other bits");

    property p_w1c;
        go && req_in.op == port_out_op && req_in.addr == {2'b00, `IOD_TMR0_FLAGS}
            && hw_flag_set_in[`IOD_TMR0_FLAGS] == `IOD_NO_MASK
        |=> io_reg_out[`IOD_TMR0_FLAGS] == ($past(io_reg_out[`IOD_TMR0_FLAGS]) & ~$past(req_in.wdata));
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag write-one-to-clear wrong");

    c_ext: cover property (ext_out.valid ##1 rsp_out.ack);
    c_err: cover property (rsp_out.err);
    c_skip: cover property (rsp_out.skip);
endmodule

bind iod_space_decode iod_chk chk_u (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .req_in(req_in),
    .hw_status_in(hw_status_in),
    .hw_flag_set_in(hw_flag_set_in),
    .rsp_out(rsp_out),
    .ext_out(ext_out),
    .io_reg_out(io_reg_out)
);

`default_nettype wire

/* File: tb.sv */
// self-checking bench for the i/o register space decoder
// assumes iod_pkg, iod_space_decode, iod_ext_model and the checker are compiled first
`include "iod_params.svh"
`timescale 1ns/10ps
`default_nettype none

module tb
    import iod_pkg::*;
;
    logic ref_clk_in;
    logic rst_n_in;
    iod_req_t req;
    iod_rsp_t rsp_w;
    iod_rsp_t rsp;
    iod_ext_t ext_w;
    wire logic [7:0] ext_rd;
    logic [7:0] hw_st [`IOD_IO_SPAN];
    logic [7:0] hw_fs [`IOD_IO_SPAN];
    logic [7:0] io_reg [`IOD_IO_SPAN];
    logic [15:0] lf;
    logic [7:0] rw_regs [8] = '{8'h01, 8'h02, 8'h0A, 8'h1E, 8'h20, 8'h2A, 8'h2B, 8'h32};
    iod_op_t t_op [8] = '{port_in_op, port_in_op, set_single_bit_op, skip_if_bit_clear_op,
        load_direct_op, store_indirect_op, clear_single_bit_op, load_displaced_op};
    logic [7:0] t_ad [8] = '{8'h80, 8'h3F, 8'h20, 8'h20, 8'h1F, 8'h00, 8'h1F, 8'h5F};
    logic [7:0] t_er = 8'h3D;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;

    iod_space_decode dut_u (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .req_in(req),
        .hw_status_in(hw_st),
        .hw_flag_set_in(hw_fs),
        .ext_rdata_in(ext_rd),
        .rsp_out(rsp_w),
        .ext_out(ext_w),
        .io_reg_out(io_reg)
    );
    iod_ext_model far_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ext_in(ext_w), .rdata_out(ext_rd));

    // ====================
    // helpers
    function automatic logic [15:0] nxt();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction

    function automatic logic [7:0] f_bitop(input logic [7:0] v, input logic set, input logic [2:0] b);
        return set ? (v | (8'h01 << b)) : (v & ~(8'h01 << b));
    endfunction

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %0t byte %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %0t bit %b expected %b", $time, g, e);
        end
    endtask

    task automatic report_and_stop();
        if (n_fail == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // one request; valid only for the taking edge, then wait for ack
    task automatic acc(input iod_op_t op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d);
        int n;
        n = 0;
        req = '{1'b1, op, a, b, d};
        @(posedge ref_clk_in);
        #1;
        req.valid = 1'b0;
        while (rsp_w.ack !== 1'b1 && n < 3) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        rsp = rsp_w;
        chk1(rsp_w.ack, 1'b1);
        @(posedge ref_clk_in);
        #1;
    endtask

    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            $display("MISMATCH %0t run did not finish", $time);
            report_and_stop();
        end
    end

    initial begin
        logic [15:0] r;
        logic [7:0] a;
        logic [7:0] e;
        iod_op_t lop;
        rst_n_in = 1'b0;
        req = '0;
        lf = 16'h8967;
        foreach (hw_fs[i]) hw_fs[i] = 8'h00;
        foreach (hw_st[i]) hw_st[i] = 8'(nxt());
        repeat (10) @(posedge ref_clk_in);
        #1;
        rst_n_in = 1'b1;
        foreach (io_reg[i]) chk8(io_reg[i], `IOD_RESET_VAL);
        // ====================
        // random bytes through both views of full-width registers
        for (int i = 0; i < 24; i++) begin
            r = nxt();
            a = rw_regs[r[2:0]];
            lop = iod_op_t'(4'h6 + 4'h2 * (r[5:4] % 2'h3));
            if (r[3]) begin
                acc(port_out_op, a, 3'h0, r[15:8]);
                acc(lop, a + `IOD_DATA_IO_BASE, 3'h0, 8'h00);
            end else begin
                acc(iod_op_t'(lop + 4'h1), a + `IOD_DATA_IO_BASE, 3'h0, r[15:8]);
                acc(port_in_op, a, 3'h0, 8'h00);
            end
            chk8(rsp.rdata, r[15:8]);
            chk8(io_reg[a[5:0]], r[15:8]);
        end
        // ====================
        // refused and boundary requests
        for (int i = 0; i < 8; i++) begin
            acc(t_op[i], t_ad[i], 3'h0, 8'h00);
            chk1(rsp.err, t_er[i]);
        end
        // reserved place and reserved bits, written on purpose
        acc(port_out_op, 8'h18, 3'h0, `IOD_FULL_MASK);
        acc(port_in_op, 8'h18, 3'h0, 8'h00);
        chk8(rsp.rdata, `IOD_NO_MASK);
        acc(port_out_op, {2'b00, `IOD_PORT_G_OUT}, 3'h0, `IOD_FULL_MASK);
        chk8(io_reg[`IOD_PORT_G_OUT], `IOD_PORT_G_MASK);
        acc(port_in_op, 8'h00, 3'h0, 8'h00);
        chk8(rsp.rdata, hw_st[0]);
        // ====================
        // single-bit set and clear
        e = 8'(nxt());
        acc(store_direct_op, 8'h3E, 3'h0, e);
        for (int i = 0; i < 10; i++) begin
            r = nxt();
            acc(r[0] ? set_single_bit_op : clear_single_bit_op, 8'h1E, r[3:1], 8'h00);
            e = f_bitop(e, r[0], r[3:1]);
            chk8(io_reg[`IOD_SCRATCH0], e);
        end
        // flags: set by hardware, cleared by writing one
        hw_fs[`IOD_TMR0_FLAGS] = `IOD_TMR0_FLAG_MASK;
        @(posedge ref_clk_in);
        #1;
        hw_fs[`IOD_TMR0_FLAGS] = 8'h00;
        acc(port_out_op, 8'h15, 3'h0, 8'h00);
        chk8(io_reg[`IOD_TMR0_FLAGS], 8'h03);
        acc(set_single_bit_op, 8'h15, 3'h0, 8'h00);
        chk8(io_reg[`IOD_TMR0_FLAGS], 8'h02);
        acc(clear_single_bit_op, 8'h15, 3'h1, 8'h00);
        chk8(io_reg[`IOD_TMR0_FLAGS], 8'h02);
        acc(port_out_op, 8'h15, 3'h0, 8'h02);
        chk8(io_reg[`IOD_TMR0_FLAGS], 8'h00);
        // ====================
        // skip tests on live pin bits
        for (int i = 0; i < 8; i++) begin
            r = nxt();
            hw_st[0] = r[15:8];
            acc(r[0] ? skip_if_bit_set_op : skip_if_bit_clear_op, 8'h00, r[3:1], 8'h00);
            chk1(rsp.bit_val, r[8 + r[3:1]]);
            chk1(rsp.skip, r[8 + r[3:1]] ~^ r[0]);
        end
        // extended space through load and store only
        for (int i = 0; i < 4; i++) begin
            r = nxt();
            a = (r[7:0] < `IOD_EXT_BASE) ? r[7:0] + 8'hA0 : r[7:0];
            acc(store_displaced_op, a, 3'h0, r[15:8]);
            acc(load_indirect_op, a, 3'h0, 8'h00);
            chk8(rsp.rdata, r[15:8]);
        end
        report_and_stop();
    end
endmodule

`default_nettype wire
